// [src/ueos_defines.svh]
// constants for the control endpoint out-success flag block
// assumes inclusion by bare name from the ueos_clr_arm and ueos_top design files
`ifndef UEOS_DEFINES_SVH
`define UEOS_DEFINES_SVH
`define UEOS_SUCCESS_BIT 0
`define UEOS_FLAG_RESET 1'b0
`endif

// [src/ueos_pkg.sv]
// types shared by the control endpoint out-success flag block
// assumes a tool that compiles packages before modules
package ueos_pkg;
  // token and handshake events seen by endpoint 0, one-cycle pulses
  typedef struct packed {
    logic setup_tok;    // setup token received
    logic out_ack;      // ack sent after out token and data
    logic setup_done;   // setup data accepted
    logic setup_local;  // command handled inside the core
  } ueos_ev_t;
  // cpu side access to the success bit
  typedef struct packed {
    logic rd;   // read of the flag register
    logic wr;   // write of the flag register
    logic wd;   // written value of the success bit
  } ueos_cpu_t;
  typedef enum logic [1:0] {
    UEOS_IDLE = 2'b00,
    UEOS_SEEN = 2'b01
  } ueos_rd_t;
endpackage

// [src/ueos_clr_arm.sv]
// read-then-write-zero clear qualifier for one flag
// assumes cpu strobes are one-cycle pulses on ref_clk
`timescale 1ns/1ns
`include "ueos_defines.svh"
module ueos_clr_arm
  import ueos_pkg::*;
(
  input wire logic ref_clk,        // system clock
  input wire logic srst,           // sync reset, high
  input wire ueos_cpu_t cpu,       // cpu access
  input wire logic flag,           // current flag value
  output logic clr                 // qualified clear request
);
  ueos_rd_t st_reg;
  ueos_rd_t st_next;

  // ---------------------------------------------
  // arm on reading a one, clear on writing a zero
  // ---------------------------------------------
  always_comb begin
    st_next = st_reg;
    clr = 1'b0;
    case (st_reg)
      UEOS_IDLE: begin
        if (cpu.rd && flag) begin
          st_next = UEOS_SEEN;
        end
      end
      UEOS_SEEN: begin
        if (cpu.wr) begin
          clr = !cpu.wd;
          st_next = UEOS_IDLE;
        end
      end
      default: begin
        st_next = UEOS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= UEOS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [src/ueos_top.sv]
// What this block does
// - success bit reads one after normal endpoint 0 out transfer or setup needing the cpu, else zero
// - cpu clears the bit by writing zero after reading one
// - a setup token on endpoint 0 clears the success bit
// - ack sent after out token and data sets the success bit
// - setup handled in core sets failure flag, not success
// - setup needing the cpu sets success when intercept is zero
// - intercept one suppresses both flags for setup transactions
//
// assumes token decode upstream delivers one-cycle event pulses
`timescale 1ns/1ns
`include "ueos_defines.svh"
module ueos_top
  import ueos_pkg::*;
(
  input wire logic ref_clk,            // 20 MHz clock
  input wire logic srst,               // sync reset, high
  input wire ueos_ev_t ev,             // endpoint 0 events
  input wire ueos_cpu_t cpu,           // cpu access to success bit
  input wire logic setup_intercept_ctl, // intercept setup flags
  output logic ctrl_ep_out_success_flag, // success flag
  output logic ctrl_ep_out_failure_set   // pulse into failure reg
);
  logic succ_reg;
  logic succ_next;
  logic fail_reg;
  logic fail_next;
  logic clr;
  logic setup_cpu;
  logic setup_core;

  // ---------------------------------------------
  // setup outcome decode
  // ---------------------------------------------
  // the flag logic and the checks on setup_cpu and setup_core share one decode; a_core_fail_pulse
  // and a_cpu_setup_set restate it; local_cmd picks the in-core outcome (1) or the cpu outcome (0)
  function automatic logic setup_sel(input ueos_ev_t e, input logic icpt,
    input logic local_cmd);
    return e.setup_done && (e.setup_local == local_cmd) && !icpt;
  endfunction

  // ---------------------------------------------
  // timing notes
  // ---------------------------------------------
  // every event is a one-cycle pulse taken at a rising edge; the flag and
  // the failure pulse answer one edge later
  // the setup token only clears; any setting for a setup transaction
  // waits for the command outcome, which arrives later as setup_done
  // a set and a clear in the same cycle leave the flag set, so software
  // never loses a completion that raced with its own clear
  // limitation: the failure flag itself lives outside this block, which
  // only hands it a one-cycle set pulse
  // limitation: arming by a read of one lasts until the next write of any
  // value, so a stray write of one disarms without clearing

  ueos_clr_arm u_arm (
    .ref_clk(ref_clk),
    .srst(srst),
    .cpu(cpu),
    .flag(succ_reg),
    .clr(clr)
  );

  // ---------------------------------------------
  // flag update; a set beats a clear in the same cycle
  // ---------------------------------------------
  always_comb begin
    setup_cpu = setup_sel(ev, setup_intercept_ctl, 1'b0);
    setup_core = setup_sel(ev, setup_intercept_ctl, 1'b1);
    succ_next = succ_reg;
    if (clr || ev.setup_tok) begin
      succ_next = 1'b0;
    end
    if (ev.out_ack || setup_cpu) begin
      succ_next = 1'b1;
    end
    fail_next = setup_core;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      succ_reg <= `UEOS_FLAG_RESET;
      fail_reg <= 1'b0;
    end else begin
      succ_reg <= succ_next;
      fail_reg <= fail_next;
    end
  end

  assign ctrl_ep_out_success_flag = succ_reg;
  assign ctrl_ep_out_failure_set = fail_reg;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_out_ack_sets: assert property (ev.out_ack |=> succ_reg)
    else $error("out ack did not set flag");
  a_setup_tok_clr: assert property (
    ev.setup_tok && !ev.out_ack && !setup_cpu |=> !succ_reg)
    else $error("setup token did not clear flag");
  a_core_fail_pulse: assert property (
    ev.setup_done && ev.setup_local && !setup_intercept_ctl
    |=> fail_reg)
    else $error("core setup did not pulse failure");
  a_core_no_succ: assert property (
    ev.setup_done && ev.setup_local && !ev.out_ack && !succ_reg
    |=> !succ_reg)
    else $error("core setup set success");
  a_cpu_setup_set: assert property (
    ev.setup_done && !ev.setup_local && !setup_intercept_ctl
    |=> succ_reg)
    else $error("cpu setup did not set flag");
  a_intercept_quiet: assert property (
    ev.setup_done && setup_intercept_ctl && !ev.out_ack && !succ_reg
    |=> !succ_reg && !fail_reg)
    else $error("intercept did not suppress flags");
  a_write_one_keep: assert property (
    succ_reg && cpu.wr && cpu.wd && !ev.setup_tok |=> succ_reg)
    else $error("write one changed flag");
  a_rise_cause: assert property (
    $rose(succ_reg) |-> $past(ev.out_ack) || $past(setup_cpu))
    else $error("flag rose without cause");
  a_reset_zero: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    $past(srst) |-> !succ_reg)
    else $error("flag not zero after reset");
  a_clear_path: assert property (
    succ_reg && cpu.rd ##1 cpu.wr && !cpu.wd && !ev.out_ack
    && !setup_cpu |=> !succ_reg)
    else $error("read then write zero did not clear");


  // ---------------------------------------------
  // refusals, pulse shape and causes
  // ---------------------------------------------
  // a write while not armed must never clear the bit
  a_unarmed_keep: assert property (
    succ_reg && u_arm.st_reg == UEOS_IDLE && cpu.wr && !ev.setup_tok
    |=> succ_reg)
    else $error("unarmed write cleared flag");
  // the clear request only comes from an armed write of zero
  a_clr_needs_arm: assert property (
    clr |-> u_arm.st_reg == UEOS_SEEN && cpu.wr && !cpu.wd)
    else $error("clear without armed zero write");
  // the failure output is a pulse, never stretched
  a_fail_one_shot: assert property (
    fail_reg && !setup_core |=> !fail_reg)
    else $error("failure pulse stretched");
  // no failure pulse without a setup outcome
  a_fail_cause: assert property (
    !ev.setup_done |=> !fail_reg)
    else $error("failure pulse without setup outcome");
  // intercept silences the failure pulse as well
  a_icpt_no_fail: assert property (
    setup_intercept_ctl |=> !fail_reg)
    else $error("intercept did not block failure pulse");
  // the bit only drops through a clear or a setup token
  a_fall_cause: assert property (
    $fell(succ_reg) |-> $past(clr) || $past(ev.setup_tok))
    else $error("flag fell without cause");
  // an out ack wins over a same-cycle setup token
  a_set_wins: assert property (
    ev.setup_tok && ev.out_ack |=> succ_reg)
    else $error("clear beat a same-cycle set");
  // with no event the bit holds its value
  a_hold_quiet: assert property (
    !ev.out_ack && !setup_cpu && !ev.setup_tok && !clr
    |=> succ_reg == $past(succ_reg))
    else $error("flag changed with no event");
  // the arming state leaves reset idle
  a_arm_reset: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    $past(srst) |-> u_arm.st_reg == UEOS_IDLE)
    else $error("clear arming not idle after reset");
  // the failure pulse is low after reset
  a_fail_reset: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    $past(srst) |-> !fail_reg)
    else $error("failure pulse not low after reset");

  // ---------------------------------------------
  // scenario covers
  // ---------------------------------------------
  c_out_ack: cover property (ev.out_ack ##1 succ_reg);
  c_cpu_setup: cover property (setup_cpu ##1 succ_reg);
  c_clear: cover property (succ_reg && cpu.rd ##1 cpu.wr ##1 !succ_reg);
  c_intercept: cover property (ev.setup_done && setup_intercept_ctl);
  c_core: cover property (fail_reg);
endmodule

// [verif/ueos_host_model.sv]
// host model: turns a transaction code into endpoint 0 event pulses
// assumes the bench applies codes at a falling edge, one cycle each
`timescale 1ns/1ns
module ueos_host_model
  import ueos_pkg::*;
(
  input wire logic ref_clk,    // system clock
  input wire logic [1:0] op,   // 1 out, 2 setup for cpu, 3 setup local
  output ueos_ev_t ev          // event pulses toward the core
);
  logic [1:0] pend = 2'h0;
  initial ev = '0;
  // setup is two events: token first, command outcome one cycle later
  always @(negedge ref_clk) begin
    ev.out_ack <= (op == 2'h1);
    ev.setup_tok <= op[1];
    ev.setup_done <= pend[1];
    ev.setup_local <= pend[0];
    pend <= op[1] ? op : 2'h0;
  end
endmodule

// [verif/ueos_top_tb_top.sv]
// bench for the endpoint 0 out-success flag
// assumes the host model supplies event pulses one cycle after op
`timescale 1ns/1ns
module ueos_top_tb_top;
  import ueos_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic icpt = 1'b0;
  logic fseen = 1'b0;
  logic [1:0] op = 2'h0;
  ueos_cpu_t cpu = '0;
  ueos_ev_t ev;
  logic flag;
  logic fset;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  // {op, intercept, expected flag, expected failure pulse}
  logic [4:0] rows [6] = '{5'h0a, 5'h19, 5'h0a, 5'h14, 5'h1c, 5'h12};
  ueos_host_model u_host(.ref_clk(ref_clk), .op(op), .ev(ev));
  ueos_top u_dut(.ref_clk(ref_clk), .srst(srst), .ev(ev), .cpu(cpu),
    .setup_intercept_ctl(icpt), .ctrl_ep_out_success_flag(flag),
    .ctrl_ep_out_failure_set(fset));
  initial forever #25 ref_clk = ~ref_clk;
  // the failure output is a one-cycle pulse, so latch it per row
  always @(posedge ref_clk) begin
    cyc++;
    if (fset === 1'b1) fseen <= 1'b1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic acc(input logic r, input logic w, input logic d);
    tick(1);
    cpu <= '{r, w, d};
    tick(1);
    cpu <= '0;
  endtask
  // ----------
  // main
  // ----------
  initial begin
    tick(3);
    srst <= 1'b0;
    chk(flag, 1'b0);
    foreach (rows[i]) begin
      fseen = 1'b0;
      op <= rows[i][4:3];
      icpt <= rows[i][2];
      tick(1);
      op <= 2'h0;
      tick(4);
      chk(flag, rows[i][1]);
      chk(fseen, rows[i][0]);
      $display("row %0d done", i);
    end
    acc(1'b1, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 1'b1);
    tick(1);
    chk(flag, 1'b1);
    acc(1'b0, 1'b1, 1'b0);
    tick(1);
    chk(flag, 1'b1);
    acc(1'b1, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 1'b0);
    tick(1);
    chk(flag, 1'b0);
    $display("cpu clear done");
    op <= 2'h1;
    tick(1);
    op <= 2'h0;
    tick(3);
    chk(flag, 1'b1);
    cpu <= '{1'b1, 1'b0, 1'b0};
    tick(1);
    cpu <= '{1'b0, 1'b1, 1'b0};
    tick(1);
    cpu <= '0;
    tick(1);
    chk(flag, 1'b0);
    op <= 2'h1;
    tick(1);
    op <= 2'h0;
    tick(3);
    chk(flag, 1'b1);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    chk(flag, 1'b0);
    chk(fset, 1'b0);
    $display("reset done");
    end_of_test;
  end
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
